// file: design/eeprom_memory_end.sv
// Memory end: serial command decoder, word array and programming timer
// Assumes link pins are asynchronous to mclk and synchronised here
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - 16-bit words, 256 or 512 of them
// - Read advances address after each word
// - Read: 1, 10, address, 16 bits out
// - Write: 1, 01, address, 16 bits in
// - Erase: 1, 11, address, no data
// - Enable: 1, 00, address top 11
// - Disable: 1, 00, address top 00
// - Bits captured on rising clock, select high
// - Start bit only on high sample
// - Leading low clocks are ignored
// - Falling select ends command input
// - Select low means standby, inputs ignored
// - Programming finishes within 10 ms
// - Read output drives low after last address
// - Power up refuses writes until enabled
// - Program on select fall; busy status
// - Erase sets word to all ones
module eeprom_memory_end
    import eeprom_port_pkg::*;
#(
    parameter bit LARGE        = 1'b0,
    parameter int PROG_CYCLES  = eeprom_port_pkg::PROG_MAX_CYCLES
) (
    input  wire logic      mclk,
    input  wire logic      rst,
    eeprom_link_if.memory  link,
    output logic           busy
);
    import eeprom_port_pkg::*;
    localparam int AW    = LARGE ? ADDR_LARGE_WIDTH : ADDR_SMALL_WIDTH;
    localparam int WORDS = LARGE ? WORDS_LARGE : WORDS_SMALL;
    localparam int IW    = LARGE ? 9 : 8;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_OP    = 6'h02,
        ST_ADDR  = 6'h04,
        ST_WDATA = 6'h08,
        ST_RDATA = 6'h10,
        ST_DONE  = 6'h20
    } state_type;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [2:0] sync1_q, sync2_q;
    logic       sk_prev_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync1_q   <= 3'h0;
            sync2_q   <= 3'h0;
            sk_prev_q <= 1'b0;
        end else begin
            sync1_q   <= {link.chip_select, link.serial_clock_in, link.serial_data_in};
            sync2_q   <= sync1_q;
            sk_prev_q <= sync2_q[1];
        end
    end
    logic cs, di, rise;
    assign cs   = sync2_q[2];
    assign di   = sync2_q[0];
    assign rise = cs && sync2_q[1] && !sk_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // Command engine
    logic [WORDS*16-1:0] mem_q, mem_d;
    state_type           st_q, st_d;
    logic [1:0]          op_q, op_d;
    logic [AW-1:0]       addr_q, addr_d;
    logic [15:0]         sh_q, sh_d;
    logic [4:0]          cnt_q, cnt_d;
    logic                wen_q, wen_d;
    logic                cs_q;
    logic                prog_q, prog_d;
    logic                busy_q;
    logic [31:0]         ptim_q, ptim_d;
    logic [IW-1:0]       pidx_q, pidx_d;
    logic [15:0]         pval_q, pval_d;
    logic                do_q, do_d, oe_n_q, oe_n_d;

    function automatic logic [IW-1:0] word_index(input logic [AW-1:0] a);
        return a[IW-1:0];
    endfunction

    always_comb begin
        st_d   = st_q;
        op_d   = op_q;
        addr_d = addr_q;
        sh_d   = sh_q;
        cnt_d  = cnt_q;
        wen_d  = wen_q;
        mem_d  = mem_q;
        prog_d = prog_q;
        ptim_d = ptim_q;
        pidx_d = pidx_q;
        pval_d = pval_q;
        do_d   = do_q;
        oe_n_d = oe_n_q;
        if (prog_q) begin
            if (ptim_q >= 32'(PROG_CYCLES - 1)) begin
                prog_d = 1'b0;
                mem_d[pidx_q*16 +: 16] = pval_q;
            end else begin
                ptim_d = ptim_q + 32'h1;
            end
        end
        if (!cs) begin
            st_d   = ST_IDLE;
            oe_n_d = 1'b1;
            if (cs_q && st_q == ST_DONE && wen_q && (op_q == OP_WRITE || op_q == OP_ERASE)) begin
                prog_d = 1'b1;
                ptim_d = 32'h0;
                pidx_d = word_index(addr_q);
                pval_d = (op_q == OP_ERASE) ? ERASED_WORD : sh_q;
            end
        end else if (prog_q || (cs && !cs_q && busy_q)) begin
            oe_n_d = 1'b0;
            do_d   = !prog_d;
        end else begin
            if (oe_n_q == 1'b0 && st_q == ST_IDLE && !rise) begin
                do_d = 1'b1;
            end
            if (rise) begin
                unique case (st_q)
                    ST_IDLE: begin
                        if (di) begin
                            st_d   = ST_OP;
                            oe_n_d = 1'b1;
                            cnt_d  = 5'h0;
                        end
                    end
                    ST_OP: begin
                        op_d  = {op_q[0], di};
                        cnt_d = cnt_q + 5'h1;
                        if (cnt_q == 5'h1) begin
                            st_d  = ST_ADDR;
                            cnt_d = 5'h0;
                        end
                    end
                    ST_ADDR: begin
                        addr_d = {addr_q[AW-2:0], di};
                        cnt_d  = cnt_q + 5'h1;
                        if (cnt_q == 5'(AW - 1)) begin
                            cnt_d = 5'h0;
                            if (op_q == OP_READ) begin
                                st_d   = ST_RDATA;
                                oe_n_d = 1'b0;
                                do_d   = 1'b0;
                                sh_d   = mem_q[word_index({addr_q[AW-2:0], di})*16 +: 16];
                            end else if (op_q == OP_WRITE) begin
                                st_d = ST_WDATA;
                            end else begin
                                st_d = ST_DONE;
                                if (op_q == OP_EXTENDED) begin
                                    if (addr_q[AW-2:AW-3] == EXT_ENABLE)
                                        wen_d = 1'b1;
                                    else if (addr_q[AW-2:AW-3] == EXT_DISABLE)
                                        wen_d = 1'b0;
                                end
                            end
                        end
                    end
                    ST_WDATA: begin
                        sh_d = {sh_q[14:0], di};
                        if (cnt_q == 5'(DATA_WIDTH - 1))
                            st_d = ST_DONE;
                        else
                            cnt_d = cnt_q + 5'h1;
                    end
                    ST_RDATA: begin
                        do_d  = sh_q[15];
                        sh_d  = {sh_q[14:0], 1'b0};
                        cnt_d = cnt_q + 5'h1;
                        if (cnt_q == 5'(DATA_WIDTH - 1)) begin
                            cnt_d  = 5'h0;
                            addr_d = addr_q + AW'(1);
                            sh_d   = mem_q[word_index(addr_q + AW'(1))*16 +: 16];
                        end
                    end
                    ST_DONE: begin
                        if (op_q == OP_WRITE)
                            sh_d = {sh_q[14:0], di};
                    end
                    default: st_d = ST_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_q   <= ST_IDLE;
            op_q   <= 2'h0;
            addr_q <= '0;
            sh_q   <= 16'h0;
            cnt_q  <= 5'h0;
            wen_q  <= 1'b0;
            mem_q  <= {WORDS{ERASED_WORD}};
            cs_q   <= 1'b0;
            prog_q <= 1'b0;
            ptim_q <= 32'h0;
            pidx_q <= '0;
            pval_q <= 16'h0;
            do_q   <= 1'b0;
            oe_n_q <= 1'b1;
            busy_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            op_q   <= op_d;
            addr_q <= addr_d;
            sh_q   <= sh_d;
            cnt_q  <= cnt_d;
            wen_q  <= wen_d;
            mem_q  <= mem_d;
            cs_q   <= cs;
            prog_q <= prog_d;
            ptim_q <= ptim_d;
            pidx_q <= pidx_d;
            pval_q <= pval_d;
            do_q   <= do_d;
            oe_n_q <= oe_n_d;
            busy_q <= prog_d;
        end
    end
    assign link.data_out_o    = do_q;
    assign link.data_out_oe_n = oe_n_q;
    assign busy               = busy_q;
endmodule
`default_nettype wire

// file: design/eeprom_port_pkg.sv
// Package for the serial word-memory command port and its host end
// Assumes both ends share one system clock mclk at 200 MHz
package eeprom_port_pkg;
    localparam int          CLK_PERIOD_PS       = 5000;
    localparam int          DATA_WIDTH          = 16;
    localparam int          OPCODE_WIDTH        = 2;
    localparam int          ADDR_SMALL_WIDTH    = 8;
    localparam int          ADDR_LARGE_WIDTH    = 10;
    localparam int          WORDS_SMALL         = 256;
    localparam int          WORDS_LARGE         = 512;
    localparam logic [1:0]  OP_EXTENDED         = 2'h0;
    localparam logic [1:0]  OP_WRITE            = 2'h1;
    localparam logic [1:0]  OP_READ             = 2'h2;
    localparam logic [1:0]  OP_ERASE            = 2'h3;
    localparam logic [1:0]  EXT_ENABLE          = 2'h3;
    localparam logic [1:0]  EXT_DISABLE         = 2'h0;
    localparam logic [15:0] ERASED_WORD         = 16'hffff;
    // Programming time in microseconds, typical and longest
    localparam int          PROG_TYP_US         = 4000;
    localparam int          PROG_MAX_US         = 10000;
    // Divide first so the product stays inside a 32-bit int
    localparam int          PROG_MAX_CYCLES     = PROG_MAX_US * (1000000 / CLK_PERIOD_PS);
    // Deselect interval in nanoseconds, least
    localparam int          DESELECT_NS         = 200;
    localparam int          DESELECT_CYCLES     =
        (DESELECT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Host serial clock divider: half period in mclk cycles
    localparam int          HOST_HALF_CYCLES    = 8;
    localparam int          LINK_HALF_NS        = 40;
endpackage

// file: design/eeprom_link_if.sv
// Link between the memory end and the host end
// Assumes the bench resolves the data output from its enable
`timescale 1ns/100ps
`default_nettype none
interface eeprom_link_if;
    logic chip_select;
    logic serial_clock_in;
    logic serial_data_in;
    logic data_out_o;
    logic data_out_oe_n;
    modport memory (input chip_select, serial_clock_in, serial_data_in,
                    output data_out_o, data_out_oe_n);
    modport host (output chip_select, serial_clock_in, serial_data_in,
                  input data_out_o, data_out_oe_n);
endinterface
`default_nettype wire

// file: design/eeprom_host_end.sv
// Host end: shifts one command out, clocks data back, waits ready
// Assumes the memory end data output is asynchronous and synchronised here
`timescale 1ns/100ps
`default_nettype none
module eeprom_host_end
    import eeprom_port_pkg::*;
#(
    parameter bit LARGE = 1'b0
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    eeprom_link_if.host      link,
    input  wire logic        cmd_valid,
    input  wire logic [1:0]  cmd_op,
    input  wire logic [9:0]  cmd_addr,
    input  wire logic [15:0] cmd_wdata,
    input  wire logic        cmd_verify,
    output logic             cmd_ready,
    output logic             rsp_valid,
    output logic [15:0]      rsp_rdata
);
    import eeprom_port_pkg::*;
    localparam int AW = LARGE ? ADDR_LARGE_WIDTH : ADDR_SMALL_WIDTH;
    localparam int NB = 1 + OPCODE_WIDTH + AW + DATA_WIDTH;

    typedef enum logic [4:0] {
        H_IDLE  = 5'h01,
        H_SHIFT = 5'h02,
        H_READ  = 5'h04,
        H_GAP   = 5'h08,
        H_WAIT  = 5'h10
    } hstate_type;

    ////////////////////////////////////////////////////////////////////////
    // Data output synchroniser
    logic [1:0] s1_q, s2_q;
    logic       dout_seen;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1_q <= 2'h1;
            s2_q <= 2'h1;
        end else begin
            s1_q <= {link.data_out_o, link.data_out_oe_n};
            s2_q <= s1_q;
        end
    end
    // Data level counts only while the memory end drives it
    assign dout_seen = s2_q[1] & ~s2_q[0];

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    hstate_type       st_q, st_d;
    logic [NB-1:0]    sh_q, sh_d;
    logic [5:0]       bits_q, bits_d;
    logic [3:0]       div_q, div_d;
    logic             cs_q, cs_d, sk_q, sk_d, di_q, di_d;
    logic             rd_q, rd_d, vf_q, vf_d;
    logic [15:0]      rx_q, rx_d;
    logic             ready_q, ready_d, rv_q, rv_d;
    logic [7:0]       gap_q, gap_d;
    logic             half;

    assign half = (div_q == 4'(HOST_HALF_CYCLES - 1));

    always_comb begin
        st_d = st_q; sh_d = sh_q; bits_d = bits_q; div_d = div_q;
        cs_d = cs_q; sk_d = sk_q; di_d = di_q; rd_d = rd_q; vf_d = vf_q;
        rx_d = rx_q; ready_d = ready_q; rv_d = 1'b0; gap_d = gap_q;
        div_d = half ? 4'h0 : div_q + 4'h1;
        unique case (st_q)
            H_IDLE: begin
                if (cmd_valid && ready_q) begin
                    ready_d = 1'b0;
                    cs_d    = 1'b1;
                    div_d   = 4'h0;
                    rd_d    = (cmd_op == OP_READ);
                    vf_d    = cmd_verify && (cmd_op == OP_WRITE || cmd_op == OP_ERASE);
                    di_d    = 1'b1;
                    sh_d    = {cmd_op, cmd_addr[AW-1:0], cmd_wdata, 1'b0};
                    bits_d  = (cmd_op == OP_WRITE) ? 6'(NB) : 6'(NB - DATA_WIDTH);
                    st_d    = H_SHIFT;
                end
            end
            H_SHIFT: if (half) begin
                // Next bit is set up as the clock falls, never with a rise
                if (sk_q) begin
                    sk_d   = 1'b0;
                    di_d   = sh_q[NB-1];
                    sh_d   = {sh_q[NB-2:0], 1'b0};
                    bits_d = bits_q - 6'h1;
                end else if (bits_q == 6'h0) begin
                    st_d   = rd_q ? H_READ : H_GAP;
                    bits_d = 6'(DATA_WIDTH);
                    di_d   = 1'b0;
                    if (!rd_q) cs_d = 1'b0;
                end else begin
                    sk_d = 1'b1;
                end
            end
            H_READ: if (half) begin
                sk_d = !sk_q;
                di_d = 1'b0;
                if (sk_q) begin
                    rx_d   = {rx_q[14:0], dout_seen};
                    bits_d = bits_q - 6'h1;
                    if (bits_q == 6'h1) begin
                        cs_d = 1'b0;
                        sk_d = 1'b0;
                        rv_d = 1'b1;
                        st_d = H_GAP;
                    end
                end
            end
            H_GAP: begin
                sk_d  = 1'b0;
                di_d  = 1'b0;
                gap_d = gap_q + 8'h1;
                if (gap_q >= 8'(DESELECT_CYCLES + 2)) begin
                    gap_d = 8'h0;
                    if (vf_q) begin
                        cs_d = 1'b1;
                        st_d = H_WAIT;
                    end else begin
                        ready_d = 1'b1;
                        st_d    = H_IDLE;
                    end
                end
            end
            H_WAIT: begin
                gap_d = (gap_q == 8'hff) ? gap_q : gap_q + 8'h1;
                if (gap_q > 8'h8 && dout_seen) begin
                    cs_d = 1'b0;
                    vf_d = 1'b0;
                    gap_d = 8'h0;
                    st_d = H_GAP;
                end
            end
            default: st_d = H_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_q <= H_IDLE; sh_q <= '0; bits_q <= 6'h0; div_q <= 4'h0;
            cs_q <= 1'b0; sk_q <= 1'b0; di_q <= 1'b0; rd_q <= 1'b0; vf_q <= 1'b0;
            rx_q <= 16'h0; ready_q <= 1'b1; rv_q <= 1'b0; gap_q <= 8'h0;
        end else begin
            st_q <= st_d; sh_q <= sh_d; bits_q <= bits_d; div_q <= div_d;
            cs_q <= cs_d; sk_q <= sk_d; di_q <= di_d; rd_q <= rd_d; vf_q <= vf_d;
            rx_q <= rx_d; ready_q <= ready_d; rv_q <= rv_d; gap_q <= gap_d;
        end
    end
    assign link.chip_select     = cs_q;
    assign link.serial_clock_in = sk_q;
    assign link.serial_data_in  = di_q;
    assign cmd_ready            = ready_q;
    assign rsp_valid            = rv_q;
    assign rsp_rdata            = rx_q;
endmodule
`default_nettype wire

// file: dv/eeprom_link_checker.sv
// Checker for the serial word-memory link pins and the programming flag
// Assumes the bench instantiates it beside the link interface
`timescale 1ns/100ps
`default_nettype none
module eeprom_link_checker #(
    parameter int PROG_CYCLES = 200
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic chip_select,
    input wire logic serial_clock_in,
    input wire logic serial_data_in,
    input wire logic data_out_o,
    input wire logic data_out_oe_n,
    input wire logic busy
);
    int unsigned busy_cnt_q;
    int unsigned busy_cnt_d;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Length of the current programming cycle
    always_comb begin
        busy_cnt_d = busy ? busy_cnt_q + 1 : 0;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            busy_cnt_q <= 0;
        end else begin
            busy_cnt_q <= busy_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    default clocking dc @(posedge mclk); endclocking
    default disable iff (rst);

    a_standby_output_off: assert property (!chip_select [*8] |-> data_out_oe_n)
        else $error("data output driven in standby");
    a_select_fall_release: assert property ($fell(chip_select) |-> ##[1:6] data_out_oe_n)
        else $error("data output not released after deselect");
    a_program_after_deselect: assert property ($rose(busy) |-> !chip_select)
        else $error("programming began while selected");
    a_busy_status_low: assert property (
        (busy && chip_select) [*8] |-> !data_out_oe_n && !data_out_o)
        else $error("busy status not shown low");
    a_program_time_bound: assert property (busy_cnt_q <= PROG_CYCLES + 1)
        else $error("programming cycle too long");
    a_ready_after_program: assert property (
        $fell(busy) && chip_select && $past(chip_select, 4) |-> data_out_o && !data_out_oe_n)
        else $error("ready status not shown high");
    a_drive_low_first: assert property (
        $fell(data_out_oe_n) |-> chip_select && !data_out_o)
        else $error("data output did not start low");
    a_data_setup_order: assert property (
        chip_select && $changed(serial_data_in) |-> !serial_clock_in [*4])
        else $error("data input changed near a rising clock");
endmodule
`default_nettype wire

// file: dv/serial_eeprom_command_port_tb.sv
// Bench joining host end and memory end over the link, with a word model
// Assumes the design package and link interface are compiled first
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_command_port_tb;
    import eeprom_port_pkg::*;
    localparam int PROG_SIM = 200;
    logic        mclk;
    logic        rst;
    logic        cmd_valid;
    logic [1:0]  cmd_op;
    logic [9:0]  cmd_addr;
    logic [15:0] cmd_wdata;
    logic        cmd_verify;
    logic        cmd_ready;
    logic        rsp_valid;
    logic [15:0] rsp_rdata;
    logic        busy;
    int          n_errors;
    int          comparisons;
    int          model_mem [WORDS_SMALL];
    bit          model_wen;
    int          k;
    logic [1:0]  rop;
    logic [7:0]  raddr;

    eeprom_link_if link ();
    eeprom_memory_end #(.LARGE(1'b0), .PROG_CYCLES(PROG_SIM)) eeprom_memory_end_inst (
        .mclk(mclk), .rst(rst), .link(link.memory), .busy(busy));
    eeprom_host_end #(.LARGE(1'b0)) eeprom_host_end_inst (
        .mclk(mclk), .rst(rst), .link(link.host), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_verify(cmd_verify),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
    eeprom_link_checker #(.PROG_CYCLES(PROG_SIM)) eeprom_link_checker_inst (
        .mclk(mclk), .rst(rst), .chip_select(link.chip_select),
        .serial_clock_in(link.serial_clock_in), .serial_data_in(link.serial_data_in),
        .data_out_o(link.data_out_o), .data_out_oe_n(link.data_out_oe_n), .busy(busy));

    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic finish_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check_data(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_flag(input string name, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    // One command through the host end; returns read word and whether programming ran
    task automatic run_cmd(input logic [1:0] op, input logic [7:0] addr, input logic [15:0] wdata,
                           input logic verify, output logic [15:0] rdata, output logic saw_busy);
        int i;
        rdata = 16'hxxxx;
        saw_busy = 1'b0;
        cmd_op <= op;
        cmd_addr <= {2'h0, addr};
        cmd_wdata <= wdata;
        cmd_verify <= verify;
        cmd_valid <= 1'b1;
        @(posedge mclk);
        for (i = 0; i < 100 && cmd_ready !== 1'b1; i++) begin
            @(posedge mclk);
        end
        if (i == 100) begin
            n_errors++;
            $display("MISMATCH command_taken expected 1 seen 0");
            finish_test();
        end
        cmd_valid <= 1'b0;
        @(posedge mclk);
        for (i = 0; i < 20000 && cmd_ready !== 1'b1; i++) begin
            @(posedge mclk);
            if (rsp_valid === 1'b1) begin
                rdata = rsp_rdata;
            end
            if (busy === 1'b1) begin
                saw_busy = 1'b1;
            end
        end
        if (i == 20000) begin
            n_errors++;
            $display("MISMATCH command_done expected 1 seen 0");
            finish_test();
        end
    endtask

    // Runs a command and compares it with the word model
    task automatic do_op(input logic [1:0] op, input logic [7:0] addr, input logic [15:0] wdata);
        logic [15:0] rdata;
        logic        saw_busy;
        logic        prog;
        prog = model_wen && (op == OP_WRITE || op == OP_ERASE);
        run_cmd(op, addr, wdata, prog, rdata, saw_busy);
        check_flag("programming", prog, saw_busy);
        if (op == OP_READ) begin
            check_data("read_word", model_mem[addr][15:0], rdata);
        end
        if (prog) begin
            model_mem[addr] = (op == OP_ERASE) ? ERASED_WORD : wdata;
        end
        if (op == OP_EXTENDED && addr[7:6] == EXT_ENABLE) begin
            model_wen = 1'b1;
        end
        if (op == OP_EXTENDED && addr[7:6] == EXT_DISABLE) begin
            model_wen = 1'b0;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = 2'h0;
        cmd_addr = 10'h000;
        cmd_wdata = 16'h0000;
        cmd_verify = 1'b0;
        n_errors = 0;
        comparisons = 0;
        model_wen = 1'b0;
        for (k = 0; k < WORDS_SMALL; k++) begin
            model_mem[k] = 16'hffff;
        end
        void'($urandom(32'h4d08));
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        do_op(OP_READ, 8'hff, 16'h0000);
        do_op(OP_WRITE, 8'hff, 16'h1234);
        do_op(OP_READ, 8'hff, 16'h0000);
        do_op(OP_EXTENDED, {EXT_ENABLE, 6'($urandom())}, 16'h0000);
        do_op(OP_WRITE, 8'hff, 16'h0000);
        do_op(OP_WRITE, 8'h00, 16'($urandom()));
        do_op(OP_READ, 8'h00, 16'h0000);
        do_op(OP_READ, 8'hff, 16'h0000);
        do_op(OP_ERASE, 8'hff, 16'h0000);
        do_op(OP_READ, 8'hff, 16'h0000);
        do_op(OP_EXTENDED, {EXT_DISABLE, 6'($urandom())}, 16'h0000);
        do_op(OP_ERASE, 8'h00, 16'h0000);
        do_op(OP_READ, 8'h00, 16'h0000);
        for (k = 0; k < 24; k++) begin
            rop = 2'($urandom_range(3, 0));
            raddr = 8'($urandom_range(255, 0));
            if (rop == OP_EXTENDED) begin
                raddr[7:6] = ($urandom_range(1, 0) == 1) ? EXT_ENABLE : EXT_DISABLE;
            end
            do_op(rop, raddr, 16'($urandom()));
            do_op(OP_READ, raddr, 16'h0000);
        end
        finish_test();
    end
endmodule
`default_nettype wire
